// ===== verilog/fmr_map.svh
// Constants of the metering responder: command codes, lengths, byte positions and sizes
`ifndef FMR_MAP_SVH
`define FMR_MAP_SVH

// ==========================================================================
// Command bytes on the link
// ==========================================================================
`define FMR_PREFIX 8'hA5
`define FMR_CODE_CFG_MET 8'hC1
`define FMR_CODE_DAT_MET 8'hD1
`define FMR_CODE_CFG_DEM 8'hC2
`define FMR_CODE_DAT_DEM 8'hD2
`define FMR_CODE_CFG_PEAK 8'hC3
`define FMR_CODE_DAT_PEAK 8'hD3
`define FMR_CODE_ACK 8'hB9

// ==========================================================================
// Length bytes of the data messages
// ==========================================================================
`define FMR_LEN_DAT_MET 8'h54
`define FMR_LEN_DAT_DEM 8'h36

// ==========================================================================
// Byte positions inside a message (index of first byte is zero)
// ==========================================================================
`define FMR_SUM_IDX_CFG_MET 7'h5B
`define FMR_SUM_IDX_CFG_DEM 7'h43
`define FMR_SUM_IDX_DAT_MET 7'h53
`define FMR_SUM_IDX_DAT_DEM 7'h35
`define FMR_LINE_CFG_IDX 7'h4C
`define FMR_CODE_IDX 7'h01

// ==========================================================================
// Status byte and image sizes
// ==========================================================================
`define FMR_STATUS_BIT 4
`define FMR_CFG_MET_BYTES 91
`define FMR_CFG_DEM_BYTES 67
`define FMR_SNAP_BYTES 83
`define FMR_SNAP_BITS 664
`define FMR_DEM_PAD_BITS 240
`define FMR_FIFO_DEPTH 32
`define FMR_FIFO_WIDTH 8

`endif

// ===== verilog/fmr_pkg.sv
// Types shared by the metering responder files
package fmr_pkg;

  // ==========================================================================
  // Sampled metering snapshot, fields sent most significant byte first
  // ==========================================================================
  typedef struct packed {
    logic [31:0] phase_scale;       // IEEE single, phase currents
    logic [31:0] neutral_scale;     // IEEE single, neutral current
    logic [383:0] samples;          // 48 bytes of integer samples
    logic [63:0] time_stamp;        // Time stamp
    logic [119:0] relay_word_banks; // 15 bytes of relay word bits
  } fmr_meter_t;

  // Demand or peak demand values
  typedef struct packed {
    logic [319:0] values;           // Five IEEE doubles IA IB IC IG negative_sequence_current
    logic [63:0] time_stamp;        // Time stamp
  } fmr_demand_t;

  // Generator state
  typedef enum logic [1:0] {
    FMR_IDLE = 2'b00,
    FMR_SEND = 2'b01,
    FMR_DRAIN = 2'b10
  } fmr_state_t;

  // Kind of block in flight
  typedef enum logic [1:0] {
    FMR_KIND_CFG_MET = 2'b00,
    FMR_KIND_DAT_MET = 2'b01,
    FMR_KIND_CFG_DEM = 2'b10,
    FMR_KIND_DAT_DEM = 2'b11
  } fmr_kind_t;

  // One byte waiting between fetch and FIFO
  typedef struct packed {
    logic valid;       // Byte present
    logic from_rom;    // Take the configuration image byte
    logic is_sum;      // Send the running checksum
    logic [7:0] data;  // Byte when neither of the above
  } fmr_stage_t;

endpackage

// ===== verilog/fmr_cfg_rom.sv
// Constant images of the metering and demand configuration blocks
`timescale 1ns/1ps
`include "fmr_map.svh"

module fmr_cfg_rom (
  input wire logic clk_i,
  input wire logic rd_en_i,
  input wire logic dem_mode_i,
  input wire logic [6:0] idx_i,
  output logic [7:0] rd_data_o
);

  // ==========================================================================
  // Metering block image, line configuration byte patched by the caller
  // ==========================================================================
  localparam logic [8*`FMR_CFG_MET_BYTES-1:0] MET_IMG = {
    128'hA5C1_5C01_0002_0604_0E01_000C_003C_0044, // Header, six channels, 14 banks
    80'h4941_0000_0000_0001_0004,                 // IA on phase scale factor
    80'h4942_0000_0000_0001_0004,                 // IB
    80'h4943_0000_0000_0001_0004,                 // IC
    80'h3837_4100_0000_0001_0008,                 // Differential a on neutral scale
    80'h3837_4200_0000_0001_0008,                 // Differential b
    80'h3837_4300_0000_0001_0008,                 // Differential c
    120'h0003_FFFF_FFFF_FFFF_0001_02FF_FFFF_00    // Calc block, then reserved zero
  };

  // Demand block image, command code byte patched by the caller
  localparam logic [8*`FMR_CFG_DEM_BYTES-1:0] DEM_IMG = {
    128'hA5C2_4401_0000_0501_0000_0004_002C_FFFF, // Header, five channels
    80'h4941_0000_0000_02FF_0000,                 // IA
    80'h4942_0000_0000_02FF_0000,                 // IB
    80'h4943_0000_0000_02FF_0000,                 // IC
    80'h4947_0000_0000_02FF_0000,                 // IG
    80'h3349_3200_0000_02FF_0000,                 // Negative sequence current
    8'h00                                         // Reserved zero
  };

  // ==========================================================================
  // Registered read, loads only when the fetch stage advances
  // ==========================================================================
  always_ff @(posedge clk_i) begin
    if (rd_en_i) begin
      if (dem_mode_i) begin
        // Out-of-range index reads zero
        rd_data_o <= (int'(idx_i) < `FMR_CFG_DEM_BYTES) ?
          DEM_IMG[8*(`FMR_CFG_DEM_BYTES-1-int'(idx_i)) +: 8] : 8'h00;
      end else begin
        rd_data_o <= (int'(idx_i) < `FMR_CFG_MET_BYTES) ?
          MET_IMG[8*(`FMR_CFG_MET_BYTES-1-int'(idx_i)) +: 8] : 8'h00;
      end
    end
  end

endmodule // fmr_cfg_rom

// ===== verilog/fmr_fifo.sv
// Byte FIFO with registered output stage for the transmit path
`timescale 1ns/1ps

module fmr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);

  localparam int AW = $clog2(DEPTH);

  // ==========================================================================
  // Elaboration check: pointer wrap needs a power of two
  // ==========================================================================
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad
    $error("fmr_fifo needs DEPTH a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_ff [DEPTH];  // Storage
  logic [AW:0] wptr_ff;              // Write pointer with wrap bit
  logic [AW:0] rptr_ff;              // Read pointer with wrap bit
  logic full;                        // No room
  logic empty;                       // Nothing stored
  logic pop;                         // Move a word to the output register

  assign full = (wptr_ff[AW] != rptr_ff[AW]) && (wptr_ff[AW-1:0] == rptr_ff[AW-1:0]);
  assign empty = (wptr_ff == rptr_ff);
  assign in_ready_o = !full;
  // Output register refills as soon as it empties or is taken
  assign pop = !empty && (!out_valid_o || out_ready_i);

  // ==========================================================================
  // Write side
  // ==========================================================================
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wptr_ff <= '0;
    end else if (in_valid_i && !full) begin
      mem_ff[wptr_ff[AW-1:0]] <= in_data_i;
      wptr_ff <= wptr_ff + 1'b1;
    end
  end

  // ==========================================================================
  // Read side, output straight from flops
  // ==========================================================================
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rptr_ff <= '0;
      out_valid_o <= 1'b0;
      out_data_o <= '0;
    end else if (pop) begin
      out_data_o <= mem_ff[rptr_ff[AW-1:0]];
      out_valid_o <= 1'b1;
      rptr_ff <= rptr_ff + 1'b1;
    end else if (out_ready_i) begin
      out_valid_o <= 1'b0;
    end
  end

endmodule // fmr_fifo

// ===== verilog/fmr_responder.sv
// Binary metering responder: parses two-byte requests and streams checksummed blocks
`timescale 1ns/1ps
`include "fmr_map.svh"

// Summary of operation
// - Meter config request returns block, length 5C
// - Config header: status, scales, six channels
// - Channel descriptors point scales at 0004/0008
// - Line configuration byte follows phase rotation
// - Currents-only calc, absent offsets are FFFF
// - Phase current indices 00-02, voltages FF
// - Config blocks end reserved zero, checksum
// - Data request returns block, length 54
// - Data block fields in fixed order
// - Samples ordered as quarter-cycle channel sets
// - Demand config requests return length 44
// - Demand config offsets and channel types
// - Demand data: status, five doubles, stamp
// - Status acknowledge clears the status byte
// - Bit 4 set at power-up, settings change
module fmr_responder #(
  parameter int FIFO_DEPTH = `FMR_FIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic phase_rotation_setting_i,
  input wire logic settings_changed_i,
  input wire fmr_pkg::fmr_meter_t meter_i,
  input wire fmr_pkg::fmr_demand_t demand_i,
  input wire fmr_pkg::fmr_demand_t peak_i,
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  input wire logic tx_ready_i,
  output logic busy_o,
  output logic settings_changed_flag_o
);

  // ==========================================================================
  // Elaboration check
  // ==========================================================================
  if (FIFO_DEPTH < 2) begin : g_bad
    $error("fmr_responder needs FIFO_DEPTH of at least 2");
  end

  // ==========================================================================
  // Declarations
  // ==========================================================================
  logic prefix_seen_ff;                       // Last byte was the prefix
  logic second_byte;                          // Current byte completes a request
  logic start_req;                            // Block request taken
  logic ack_req;                              // Status acknowledge taken
  logic known_block;                          // Code names a block
  fmr_pkg::fmr_kind_t req_kind;               // Kind decoded from the code
  fmr_pkg::fmr_state_t state_ff;              // Generator state
  fmr_pkg::fmr_state_t nxt_state;             // Next generator state
  fmr_pkg::fmr_kind_t kind_ff;                // Block in flight
  logic [7:0] code_ff;                        // Second command byte in flight
  logic [6:0] idx_ff;                         // Byte index being fetched
  logic [6:0] sum_idx;                        // Index of the checksum byte
  logic [`FMR_SNAP_BITS-1:0] snap_ff;         // Frozen data message
  logic [7:0] snap_byte;                      // Snapshot byte at idx_ff
  logic [7:0] status_byte;                    // Status byte as sent
  logic [7:0] sum_ff;                         // Running checksum
  logic flag_ff;                              // Settings changed flag
  logic busy_ff;                              // Block in progress
  fmr_pkg::fmr_stage_t stage_ff;              // Byte waiting for the FIFO
  fmr_pkg::fmr_stage_t nxt_stage;             // Byte fetched this cycle
  logic advance;                              // Fetch stage moves on
  logic push;                                 // Byte enters the FIFO
  logic [7:0] push_data;                      // Byte entering the FIFO
  logic fifo_in_ready;                        // FIFO has room
  logic [7:0] rom_data;                       // Registered image byte

  // ==========================================================================
  // Request parser
  // ==========================================================================
  assign second_byte = rx_valid_i && prefix_seen_ff;

  // Prefix tracker; a repeated prefix restarts the pair
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prefix_seen_ff <= 1'b0;
    end else if (rx_valid_i) begin
      prefix_seen_ff <= (rx_data_i == `FMR_PREFIX);
    end
  end

  // Code to block kind
  always_comb begin
    known_block = 1'b1;
    req_kind = fmr_pkg::FMR_KIND_CFG_MET;
    case (rx_data_i)
      `FMR_CODE_CFG_MET: begin
        req_kind = fmr_pkg::FMR_KIND_CFG_MET;
      end
      `FMR_CODE_DAT_MET: begin
        req_kind = fmr_pkg::FMR_KIND_DAT_MET;
      end
      `FMR_CODE_CFG_DEM, `FMR_CODE_CFG_PEAK: begin
        req_kind = fmr_pkg::FMR_KIND_CFG_DEM;
      end
      `FMR_CODE_DAT_DEM, `FMR_CODE_DAT_PEAK: begin
        req_kind = fmr_pkg::FMR_KIND_DAT_DEM;
      end
      default: begin
        known_block = 1'b0;                    // Unknown or acknowledge
      end
    endcase
  end

  // Block requests arriving mid-block are dropped, not queued
  assign start_req = second_byte && known_block && (state_ff == fmr_pkg::FMR_IDLE);
  // Acknowledge is honoured even while a block is going out
  assign ack_req = second_byte && (rx_data_i == `FMR_CODE_ACK);

  // ==========================================================================
  // Settings changed flag
  // ==========================================================================
  // Set wins over acknowledge so a change in the same cycle is not lost
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_ff <= 1'b1;            // Set at power-up
    end else if (settings_changed_i) begin
      flag_ff <= 1'b1;
    end else if (ack_req) begin
      flag_ff <= 1'b0;
    end
  end

  // Only bit 4 is ever active
  always_comb begin
    status_byte = 8'h00;
    status_byte[`FMR_STATUS_BIT] = flag_ff;
  end

  // ==========================================================================
  // Snapshot of the data message at request time
  // ==========================================================================
  // Freezing the data keeps one block self-consistent while sources move
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      snap_ff <= '0;
    end else if (start_req) begin
      if (req_kind == fmr_pkg::FMR_KIND_DAT_MET) begin
        // Command, length, status, scales, samples, stamp, relay words
        snap_ff <= {`FMR_PREFIX, rx_data_i, `FMR_LEN_DAT_MET, status_byte, meter_i};
      end else if (rx_data_i == `FMR_CODE_DAT_PEAK) begin
        // Five doubles, stamp, reserved zero
        snap_ff <= {`FMR_PREFIX, rx_data_i, `FMR_LEN_DAT_DEM, status_byte, peak_i, 8'h00,
                    {`FMR_DEM_PAD_BITS{1'b0}}};
      end else begin
        snap_ff <= {`FMR_PREFIX, rx_data_i, `FMR_LEN_DAT_DEM, status_byte, demand_i, 8'h00,
                    {`FMR_DEM_PAD_BITS{1'b0}}};
      end
    end
  end

  // Byte selected by index, most significant byte first
  assign snap_byte = (int'(idx_ff) < `FMR_SNAP_BYTES) ?
    snap_ff[8*(`FMR_SNAP_BYTES-1-int'(idx_ff)) +: 8] : 8'h00;

  // ==========================================================================
  // Block control
  // ==========================================================================
  // Checksum position per kind
  always_comb begin
    case (kind_ff)
      fmr_pkg::FMR_KIND_CFG_MET: sum_idx = `FMR_SUM_IDX_CFG_MET;
      fmr_pkg::FMR_KIND_DAT_MET: sum_idx = `FMR_SUM_IDX_DAT_MET;
      fmr_pkg::FMR_KIND_CFG_DEM: sum_idx = `FMR_SUM_IDX_CFG_DEM;
      fmr_pkg::FMR_KIND_DAT_DEM: sum_idx = `FMR_SUM_IDX_DAT_DEM;
      default: sum_idx = `FMR_SUM_IDX_CFG_MET;
    endcase
  end

  // Fetch only when the waiting byte is gone or leaves now
  assign advance = (state_ff == fmr_pkg::FMR_SEND) && (!stage_ff.valid || fifo_in_ready);
  assign push = stage_ff.valid && fifo_in_ready;

  // Next state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      fmr_pkg::FMR_IDLE: begin
        if (start_req) begin
          nxt_state = fmr_pkg::FMR_SEND;
        end
      end
      fmr_pkg::FMR_SEND: begin
        // Checksum fetched: wait for it to leave
        if (advance && (idx_ff == sum_idx)) begin
          nxt_state = fmr_pkg::FMR_DRAIN;
        end
      end
      fmr_pkg::FMR_DRAIN: begin
        if (push) begin
          nxt_state = fmr_pkg::FMR_IDLE;
        end
      end
      default: begin
        nxt_state = fmr_pkg::FMR_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= fmr_pkg::FMR_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Busy output, registered copy of the next state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_ff <= 1'b0;
    end else begin
      busy_ff <= (nxt_state != fmr_pkg::FMR_IDLE);
    end
  end

  // Kind and code of the block in flight
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      kind_ff <= fmr_pkg::FMR_KIND_CFG_MET;
      code_ff <= 8'h00;
    end else if (start_req) begin
      kind_ff <= req_kind;
      code_ff <= rx_data_i;
    end
  end

  // Byte index
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      idx_ff <= 7'h00;
    end else if (start_req) begin
      idx_ff <= 7'h00;
    end else if (advance) begin
      idx_ff <= idx_ff + 7'h01;
    end
  end

  // ==========================================================================
  // Byte fetch
  // ==========================================================================
  always_comb begin
    nxt_stage.valid = 1'b1;
    nxt_stage.from_rom = 1'b0;
    nxt_stage.is_sum = 1'b0;
    nxt_stage.data = snap_byte;
    if (idx_ff == sum_idx) begin
      nxt_stage.is_sum = 1'b1;
    end else begin
      case (kind_ff)
        fmr_pkg::FMR_KIND_CFG_MET: begin
          if (idx_ff == `FMR_LINE_CFG_IDX) begin
            nxt_stage.data = {7'h00, phase_rotation_setting_i};  // 00 ABC, 01 ACB
          end else begin
            nxt_stage.from_rom = 1'b1;
          end
        end
        fmr_pkg::FMR_KIND_CFG_DEM: begin
          if (idx_ff == `FMR_CODE_IDX) begin
            nxt_stage.data = code_ff;                            // Echo demand or peak code
          end else begin
            nxt_stage.from_rom = 1'b1;
          end
        end
        default: begin
          nxt_stage.data = snap_byte;
        end
      endcase
    end
  end

  // Waiting byte; held while the FIFO is full
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stage_ff <= '0;
    end else if (advance) begin
      stage_ff <= nxt_stage;
    end else if (push) begin
      stage_ff.valid <= 1'b0;
    end
  end

  // Image store, shares the fetch timing of the waiting byte
  fmr_cfg_rom u_rom (
    .clk_i(clk_i),
    .rd_en_i(advance),
    .dem_mode_i(kind_ff == fmr_pkg::FMR_KIND_CFG_DEM),
    .idx_i(idx_ff),
    .rd_data_o(rom_data)
  );

  // ==========================================================================
  // Checksum
  // ==========================================================================
  assign push_data = stage_ff.is_sum ? sum_ff : (stage_ff.from_rom ? rom_data : stage_ff.data);

  // Byte sum modulo 256 of everything pushed before the checksum
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sum_ff <= 8'h00;
    end else if (start_req) begin
      sum_ff <= 8'h00;
    end else if (push && !stage_ff.is_sum) begin
      sum_ff <= sum_ff + push_data;  // Carry dropped on purpose
    end
  end

  // ==========================================================================
  // Transmit FIFO
  // ==========================================================================
  // Stalls the fetch stage when the link side is slow
  fmr_fifo #(
    .WIDTH(`FMR_FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(push),
    .in_data_i(push_data),
    .in_ready_o(fifo_in_ready),
    .out_valid_o(tx_valid_o),
    .out_data_o(tx_data_o),
    .out_ready_i(tx_ready_i)
  );

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign busy_o = busy_ff;
  assign settings_changed_flag_o = flag_ff;

endmodule // fmr_responder

// ===== bench/fmr_monitor.sv
// Port checker of the metering responder
`timescale 1ns/1ps
module fmr_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic settings_changed_i,
  input wire logic tx_valid_o,
  input wire logic [7:0] tx_data_o,
  input wire logic tx_ready_i,
  input wire logic busy_o,
  input wire logic settings_changed_flag_o
);
  // ========
  logic armed_ff; // Prefix seen, next byte is a code
  logic ack;
  logic req;
  // Track the prefix the same way the responder pairs bytes
  always_ff @(posedge clk_i) begin
    if (rst_i) armed_ff <= 1'b0;
    else if (rx_valid_i) armed_ff <= (rx_data_i == 8'hA5);
  end
  assign ack = rx_valid_i && armed_ff && rx_data_i == 8'hB9;
  assign req = rx_valid_i && armed_ff && rx_data_i inside {8'hC1, 8'hD1, 8'hC2, 8'hC3, 8'hD2, 8'hD3};
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_reset_vals: assert property ($fell(rst_i) |-> !tx_valid_o && !busy_o && settings_changed_flag_o)
    else $error("outputs not in reset state");
  a_flag_set: assert property (settings_changed_i |=> settings_changed_flag_o)
    else $error("flag not set by settings change");
  a_flag_keep: assert property (!settings_changed_i && !ack |=> $stable(settings_changed_flag_o))
    else $error("flag moved without cause");
  a_ack_clear: assert property (ack && !settings_changed_i |=> !settings_changed_flag_o)
    else $error("acknowledge did not clear flag");
  a_ack_no_blk: assert property (ack && !busy_o |=> !busy_o [*2])
    else $error("acknowledge started a block");
  a_start_busy: assert property (req && !busy_o |=> busy_o [*8])
    else $error("request not taken");
  a_first_byte: assert property (req && !busy_o && !tx_valid_o |-> ##[1:6] tx_valid_o && tx_data_o == 8'hA5)
    else $error("block did not open with prefix in time");
  a_stall_hold: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
    else $error("byte lost under stall");
endmodule // fmr_monitor
bind fmr_responder fmr_monitor mon (.clk_i, .rst_i, .rx_valid_i, .rx_data_i, .settings_changed_i, .tx_valid_o,
  .tx_data_o, .tx_ready_i, .busy_o, .settings_changed_flag_o);

// ===== bench/fmr_host_model.sv
// Host side model: takes response bytes, stalls when told
`timescale 1ns/1ps
module fmr_host_model (
  input wire logic clk_i,
  input wire logic stall_i,
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_data_i,
  output logic tx_ready_o
);
  // ========
  logic [7:0] buf_q [0:127]; // Received block
  int cnt; // Bytes taken, cleared by the bench
  logic [1:0] ph_ff; // Stall phase, one take in four
  initial begin
    cnt = 0;
    ph_ff = 2'h0;
    tx_ready_o = 1'b0;
  end
  // Slow acceptance fills the transmit FIFO until it refuses
  always @(posedge clk_i) begin
    if (tx_valid_i && tx_ready_o) begin
      buf_q[cnt[6:0]] = tx_data_i;
      cnt++;
    end
    ph_ff <= ph_ff + 2'h1;
    tx_ready_o <= #1 !stall_i || ph_ff == 2'h0;
  end
endmodule // fmr_host_model

// ===== bench/tb.sv
// Testbench of the metering responder
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_errors++; $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module tb;
  // ========
  logic clk_i = 0, rst_i = 1, rx_valid_i = 0, rot = 0, chg = 0, stall = 1;
  logic [7:0] rx_data_i = 8'h00;
  logic tx_valid, tx_ready, busy, flag;
  logic [7:0] tx_data;
  fmr_pkg::fmr_meter_t met;
  fmr_pkg::fmr_demand_t dem, pk;
  int n_errors = 0, n_tests = 0;
  always #2 clk_i = ~clk_i;
  fmr_responder dut (.clk_i, .rst_i, .rx_valid_i, .rx_data_i, .phase_rotation_setting_i(rot),
    .settings_changed_i(chg), .meter_i(met), .demand_i(dem), .peak_i(pk), .tx_valid_o(tx_valid),
    .tx_data_o(tx_data), .tx_ready_i(tx_ready), .busy_o(busy), .settings_changed_flag_o(flag));
  fmr_host_model host (.clk_i, .stall_i(stall), .tx_valid_i(tx_valid), .tx_data_i(tx_data), .tx_ready_o(tx_ready));
  task automatic wrap_up;
    if (n_errors == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Received bytes a..a+n-1, first one highest
  function automatic logic [103:0] grab(input int a, input int n);
    logic [103:0] v = 0;
    for (int i = 0; i < n; i++) v = {v[95:0], host.buf_q[a+i]};
    return v;
  endfunction
  // Prefix then code, back to back
  task automatic req(input logic [7:0] c);
    rx_valid_i = 1; rx_data_i = 8'hA5; @(posedge clk_i); #1 rx_data_i = c; @(posedge clk_i); #1 rx_valid_i = 0;
  endtask
  // One block; x is a second request sent while busy
  task automatic blk(input logic [7:0] c, input logic [7:0] len, input int n, input logic [7:0] x);
    int s = 0;
    host.cnt = 0;
    req(c);
    `CHK(busy, 1'b1)
    if (x != 8'h00) begin @(posedge clk_i); #1 req(x); end
    for (int i = 0; i < 2000 && host.cnt < n; i++) @(posedge clk_i);
    if (host.cnt < n) begin n_errors++; wrap_up; end
    repeat (10) @(posedge clk_i); #1;
    `CHK(busy, 1'b0)
    `CHK(host.cnt, n)
    `CHK(grab(0, 3), {8'hA5, c, len})
    for (int i = 0; i < n - 1; i++) s += host.buf_q[i];
    `CHK(host.buf_q[n-1], 8'(s))
  endtask
  task automatic t_meter_cfg(input logic r, input logic [7:0] x);
    rot = r;
    blk(8'hC1, 8'h5C, 92, x);
    `CHK(grab(3, 13), 104'h01_0002_0604_0E01_000C_003C_0044)
    for (int k = 0; k < 6; k++) `CHK(grab(22 + 10 * k, 4), {16'h0001, k < 3 ? 16'h0004 : 16'h0008})
    `CHK(grab(76, 1), {7'h00, r})
    `CHK(grab(77, 7), 104'h03_FFFF_FFFF_FFFF)
    `CHK(grab(84, 7), 104'h00_0102_FFFF_FF00)
  endtask
  task automatic t_dem_cfg(input logic [7:0] c);
    blk(c, 8'h44, 68, 8'h00);
    `CHK(grab(3, 13), 104'h01_0000_0501_0000_0004_002C_FFFF)
    for (int k = 0; k < 5; k++) `CHK(grab(22 + 10 * k, 4), 104'h02FF_0000)
    `CHK(grab(66, 1), 104'h0)
  endtask
  task automatic t_meter_dat(input logic [7:0] st, input logic [7:0] x);
    blk(8'hD1, 8'h54, 84, x);
    `CHK(host.buf_q[3], st)
    for (int i = 0; i < 79; i++) `CHK(host.buf_q[4+i], met[(78-i)*8 +: 8])
  endtask
  task automatic t_dem_dat(input logic [7:0] c, input fmr_pkg::fmr_demand_t d, input logic [7:0] st);
    blk(c, 8'h36, 54, 8'h00);
    `CHK(host.buf_q[3], st)
    for (int i = 0; i < 48; i++) `CHK(host.buf_q[4+i], d[(47-i)*8 +: 8])
    `CHK(host.buf_q[52], 8'h00)
  endtask
  // Acknowledge while idle: no block starts; a change in the same cycle wins
  task automatic t_ack(input logic c);
    host.cnt = 0;
    rx_valid_i = 1;
    rx_data_i = 8'hA5;
    @(posedge clk_i);
    #1 rx_data_i = 8'hB9;
    chg = c;
    @(posedge clk_i);
    #1 rx_valid_i = 0;
    chg = 0;
    repeat (8) @(posedge clk_i);
    #1;
    `CHK(flag, c)
    `CHK(busy, 1'b0)
    `CHK(host.cnt, 0)
  endtask
  initial begin
    for (int i = 0; i < 79; i++) met[i*8 +: 8] = 8'(i * 3 + 1);
    for (int i = 0; i < 48; i++) dem[i*8 +: 8] = 8'(i + 100);
    for (int i = 0; i < 48; i++) pk[i*8 +: 8] = 8'(i + 200);
    repeat (20) @(posedge clk_i);
    #1 rst_i = 0;
    t_meter_dat(8'h10, 8'hB9); // Acknowledge mid-block; status was snapshotted
    `CHK(flag, 1'b0)
    stall = 0;
    t_meter_dat(8'h00, 8'hC1); // Request while busy is dropped
    t_dem_dat(8'hD2, dem, 8'h00);
    chg = 1;
    @(posedge clk_i);
    #1 chg = 0;
    `CHK(flag, 1'b1)
    stall = 1;
    t_dem_dat(8'hD3, pk, 8'h10);
    t_meter_cfg(1'b0, 8'h00); // Flag seen: re-read all configs
    t_meter_cfg(1'b1, 8'hD1);
    t_dem_cfg(8'hC2);
    t_dem_cfg(8'hC3);
    t_ack(1'b1); // Set wins over acknowledge
    t_ack(1'b0); // Plain acknowledge clears the flag
    wrap_up;
  end
endmodule // tb
